// *** src/frsr_pkg.sv ***
// floppy data rate and status register bank: shared constants and carrier types
// assumes an 8-bit host I/O port with a 16-bit address and one-cycle strobes
package frsr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// host I/O addresses
	localparam logic [15:0] ADDR_DIGITAL_OUTPUT = 16'h03F2;
	localparam logic [15:0] ADDR_TAPE_DRIVE_TYPE = 16'h03F3;
	localparam logic [15:0] ADDR_RATE_STATUS = 16'h03F4;
	localparam logic [15:0] ADDR_DATA = 16'h03F5;
	localparam logic [15:0] ADDR_CONFIG_CONTROL = 16'h03F7;

	////////////////////////////////////////////////////////////////////////////////
	// field positions and reset values
	localparam int RS_SW_RESET_BIT = 7;
	localparam int RS_LOW_POWER_BIT = 6;
	localparam int RS_WRITE_CODE_A_LSB = 2;
	localparam int OUT_RESET_N_BIT = 2;
	localparam logic [7:0] RATE_SELECT_RESET = 8'h02;
	localparam logic [1:0] DRIVE_SEL_RESET = 2'h0;
	localparam logic OUT_RESET_N_RESET = 1'b0;
	localparam logic [7:0] START_TRACK_RESET = 8'h00;
	localparam logic DENSITY_RESET = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// rate codes and drive rate fields
	localparam logic [1:0] CODE_1M = 2'h3;
	localparam logic [1:0] CODE_500 = 2'h0;
	localparam logic [1:0] CODE_300 = 2'h1;
	localparam logic [1:0] CODE_250 = 2'h2;
	localparam logic [1:0] FIELD_THREE_MODE = 2'h1;
	localparam logic [1:0] FIELD_TAPE_2M = 2'h2;

	typedef enum logic [2:0] {
		RATE_250K,
		RATE_300K,
		RATE_500K,
		RATE_1M,
		RATE_2M
	} frsr_rate_type;

	////////////////////////////////////////////////////////////////////////////////
	// precompensation delays in picoseconds, entries for codes 1 to 6
	localparam logic [2:0] WRITE_CODE_A_ZERO = 3'h7;
	localparam logic [2:0] WRITE_CODE_A_DEFAULT = 3'h0;
	localparam logic [17:0] WRITE_CODE_A_PS_SLOW [1:6] = '{18'h0_A2C6, 18'h1_458C, 18'h1_E848,
		18'h2_8B0E, 18'h3_2DCA, 18'h3_D090};
	localparam logic [17:0] WRITE_CODE_A_PS_FAST [1:6] = '{18'h0_5140, 18'h0_A2E4, 18'h0_F424,
		18'h1_4564, 18'h1_9708, 18'h1_E848};
	localparam logic [17:0] DEFAULT_PS_2M = 18'h0_5140;
	localparam logic [17:0] DEFAULT_PS_1M = 18'h0_A2C6;
	localparam logic [17:0] DEFAULT_PS_LOW = 18'h1_E848;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int RESET_MIN_NS = 100;
	localparam logic [3:0] RESET_MIN_CYCLES =
		4'((RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic request_for_master;
		logic transfer_direction;
		logic non_dma;
		logic command_busy;
		logic drive1_seeking;
		logic drive0_seeking;
	} frsr_status_type;

	typedef struct packed {
		logic [1:0] drive_sel;
		logic out_reset_n;
		logic [1:0] boot_drive;
		logic [1:0] tape_sel;
		logic [7:0] rate_select;
		logic [7:0] rate_select_shadow;
		logic [1:0] active_rate;
		logic low_power;
		logic [3:0] pulse_count;
		logic ctrl_reset;
		logic [7:0] start_track;
		logic [7:0] rdata;
		logic rvalid;
		frsr_rate_type data_rate;
		logic density;
		logic drive_density_out_hi;
		logic drive_density_out_lo;
		logic [17:0] write_code_a_ps;
	} frsr_state_type;

endpackage : frsr_pkg

// *** src/frsr_top.sv ***
// floppy data rate and status register bank: tape/drive type, rate select,
// output register reset and drive select, main status, rate and density decode
// assumes the command engine supplies the status flags and that host
// strobes are one clock long and synchronous to REF_CLK_I
//
// Contract
// (RQ1) enhanced mode 2 tape register: reserved, drive type, boot drive, tape select
// (RQ2) drive type id picks a config bit pair by drive select code
// (RQ3) rate select is write-only, hardware reset 02h, kept over soft reset
// (RQ4) active data rate comes from the latest rate select or config control write
// (RQ5) rate bits survive soft reset, hardware reset gives 250 Kbps
// (RQ6) bits 4:2 pick precompensation delay: 111 zero, 000 rate default
// (RQ7) precompensation starts at track 0 unless configured; defaults per rate
// (RQ8) bit 6 enters low power; soft reset or status/data access exits
// (RQ9) bit 7 issues the controller reset and clears itself
// (RQ10) software writes bit 5 of rate select as zero
// (RQ11) field 00 rate decode and density output per rate code
// (RQ12) field 01 code 01 is 500 Kbps; field 10 code 01 is 2 Mbps
// (RQ13) drive density outputs follow the drive type bits
// (RQ14) main status is read-only, readable any time, no delay needed
// (RQ15) software polls main status before each non-DMA data byte
// (RQ16) status bits 1:0 show drives in a seek portion
// (RQ17) status bit 4 shows a command in progress
// (RQ18) status bit 5 shows polled execution phase
// (RQ19) status bit 6 gives transfer direction once request is set
// (RQ20) status bit 7 says the host may move a data byte
// (RQ21) every rate select write is mirrored into a readable shadow
// (RQ22) drive select bits are binary encoded, one drive at a time
// (RQ23) output register reset bit low holds reset until written high
// (RQ24) reserved status bits 3 and 2 read as zero
`timescale 1ns/1ps
module frsr_top (
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic RESET_N_I,
	// host I/O port
	input wire logic [15:0] IO_ADDR_I,
	input wire logic IO_WRITE_I,
	input wire logic IO_READ_I,
	input wire logic [7:0] IO_WDATA_I,
	output logic [7:0] IO_RDATA_O,
	output logic IO_RVALID_O,
	// configuration and command engine
	input wire logic ENHANCED_MODE2_I,
	input wire logic [7:0] DRIVE_TYPE_CONFIG_I,
	input wire logic [1:0] DRIVE_RATE_FIELD_I,
	input wire logic START_TRACK_LOAD_I,
	input wire logic [7:0] START_TRACK_I,
	input wire frsr_pkg::frsr_status_type STATUS_I,
	// controller and drive outputs
	output logic CTRL_RESET_O,
	output logic LOW_POWER_O,
	output logic [1:0] DRIVE_SEL_O,
	output logic [1:0] TAPE_SEL_O,
	output frsr_pkg::frsr_rate_type DATA_RATE_O,
	output logic [2:0] WRITE_CODE_A_O,
	output logic [17:0] WRITE_CODE_A_DELAY_PS_O,
	output logic [7:0] WRITE_CODE_A_START_TRACK_O,
	output logic DENSITY_SELECT_OUT_O,
	output logic DRIVE_DENSITY_OUT_HI_O,
	output logic DRIVE_DENSITY_OUT_LO_O,
	output logic [7:0] RATE_SELECT_SHADOW_O
);

	////////////////////////////////////////////////////////////////////////////////
	// reset release through two flops
	logic rst_meta_n;
	logic rst_n;

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// decode
	frsr_pkg::frsr_state_type state;
	frsr_pkg::frsr_state_type next_state;
	logic wr_out_reg;
	logic wr_tape;
	logic wr_rate;
	logic wr_cfg_ctrl;
	logic rd_status;
	logic data_access;
	logic soft_reset;
	logic [1:0] drive_type;
	logic [7:0] tape_read;
	logic [7:0] status_read;
	logic [2:0] write_code_a_code;

	assign wr_out_reg = IO_WRITE_I && (IO_ADDR_I == frsr_pkg::ADDR_DIGITAL_OUTPUT);
	assign wr_tape = IO_WRITE_I && (IO_ADDR_I == frsr_pkg::ADDR_TAPE_DRIVE_TYPE);
	assign wr_rate = IO_WRITE_I && (IO_ADDR_I == frsr_pkg::ADDR_RATE_STATUS);
	assign wr_cfg_ctrl = IO_WRITE_I && (IO_ADDR_I == frsr_pkg::ADDR_CONFIG_CONTROL);
	assign rd_status = IO_READ_I && (IO_ADDR_I == frsr_pkg::ADDR_RATE_STATUS);
	assign data_access = (IO_READ_I || IO_WRITE_I) && (IO_ADDR_I == frsr_pkg::ADDR_DATA);
	assign soft_reset = state.ctrl_reset;
	assign write_code_a_code = state.rate_select[frsr_pkg::RS_WRITE_CODE_A_LSB +: 3];

	// one binary code selects exactly one drive's pair [RQ22] [RQ2]
	assign drive_type = DRIVE_TYPE_CONFIG_I[{state.drive_sel, 1'b0} +: 2];

	// tape register; normal mode only shows the tape select bits [RQ1]
	assign tape_read = ENHANCED_MODE2_I ?
		{2'b00, drive_type, state.boot_drive, state.tape_sel} :
		{6'h00, state.tape_sel};

	// status composed straight from live flags, so no settle time after a data move
	assign status_read = {STATUS_I.request_for_master, // [RQ20] [RQ14]
		STATUS_I.transfer_direction, // [RQ19]
		STATUS_I.non_dma, // [RQ18]
		STATUS_I.command_busy, // [RQ17]
		2'b00, // [RQ24]
		STATUS_I.drive1_seeking, // [RQ16]
		STATUS_I.drive0_seeking};

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_state = state;
		next_state.rvalid = IO_READ_I;
		if (rd_status) begin
			next_state.rdata = status_read;
		end else if (IO_READ_I && (IO_ADDR_I == frsr_pkg::ADDR_TAPE_DRIVE_TYPE)) begin
			next_state.rdata = tape_read;
		end else begin
			// write-only and foreign addresses read as zero here
			next_state.rdata = 8'h00;
		end

		if (wr_out_reg) begin
			next_state.drive_sel = IO_WDATA_I[1:0]; // [RQ22]
			next_state.out_reset_n = IO_WDATA_I[frsr_pkg::OUT_RESET_N_BIT]; // [RQ23]
		end
		if (wr_tape) begin
			next_state.tape_sel = IO_WDATA_I[1:0];
			next_state.boot_drive = IO_WDATA_I[3:2];
		end

		// bit 7 is not kept in rate_select, only in the shadow: a fresh write restarts the reset pulse [RQ9]
		if (state.pulse_count != 4'h0) begin
			next_state.pulse_count = state.pulse_count - 4'h1;
		end
		if (wr_rate) begin
			next_state.rate_select = {1'b0, IO_WDATA_I[6:0]}; // [RQ3]
			next_state.rate_select_shadow = IO_WDATA_I; // [RQ21]
			next_state.active_rate = IO_WDATA_I[1:0]; // [RQ4]
			if (IO_WDATA_I[frsr_pkg::RS_SW_RESET_BIT]) begin
				next_state.pulse_count = frsr_pkg::RESET_MIN_CYCLES; // [RQ9]
			end
		end else if (wr_cfg_ctrl) begin
			next_state.active_rate = IO_WDATA_I[1:0]; // [RQ4]
		end
		// held high while the output register reset bit is low, or pulsed by rate select [RQ23] [RQ9]
		next_state.ctrl_reset = !next_state.out_reset_n || (next_state.pulse_count != 4'h0);

		// low power: any exit condition clears, a setting write wins [RQ8]
		if (soft_reset || rd_status || data_access) begin
			next_state.low_power = 1'b0;
		end
		if (wr_rate && IO_WDATA_I[frsr_pkg::RS_LOW_POWER_BIT]) begin
			next_state.low_power = 1'b1;
		end

		if (START_TRACK_LOAD_I) begin
			next_state.start_track = START_TRACK_I; // [RQ7]
		end

		// rate decode with drive rate field overrides [RQ11] [RQ12]
		unique case (state.active_rate)
			frsr_pkg::CODE_1M: next_state.data_rate = frsr_pkg::RATE_1M;
			frsr_pkg::CODE_500: next_state.data_rate = frsr_pkg::RATE_500K;
			frsr_pkg::CODE_250: next_state.data_rate = frsr_pkg::RATE_250K;
			frsr_pkg::CODE_300: begin
				if (DRIVE_RATE_FIELD_I == frsr_pkg::FIELD_THREE_MODE) begin
					next_state.data_rate = frsr_pkg::RATE_500K;
				end else if (DRIVE_RATE_FIELD_I == frsr_pkg::FIELD_TAPE_2M) begin
					next_state.data_rate = frsr_pkg::RATE_2M;
				end else begin
					next_state.data_rate = frsr_pkg::RATE_300K;
				end
			end
		endcase
		next_state.density = (state.active_rate == frsr_pkg::CODE_1M) ||
			(state.active_rate == frsr_pkg::CODE_500); // [RQ11]

		// drive density pins by drive type [RQ13]
		unique case (drive_type)
			2'b00: begin
				next_state.drive_density_out_hi = state.active_rate[0];
				next_state.drive_density_out_lo = state.density;
			end
			2'b10: begin
				next_state.drive_density_out_hi = state.active_rate[0];
				next_state.drive_density_out_lo = state.active_rate[1];
			end
			2'b01: begin
				next_state.drive_density_out_hi = state.active_rate[0];
				next_state.drive_density_out_lo = !state.density;
			end
			2'b11: begin
				next_state.drive_density_out_hi = state.active_rate[1];
				next_state.drive_density_out_lo = state.active_rate[0];
			end
		endcase

		// precompensation delay; the 2 Mbps table is not an exact half [RQ6] [RQ7]
		if (write_code_a_code == frsr_pkg::WRITE_CODE_A_ZERO) begin
			next_state.write_code_a_ps = 18'h0_0000;
		end else if (write_code_a_code == frsr_pkg::WRITE_CODE_A_DEFAULT) begin
			if (state.data_rate == frsr_pkg::RATE_2M) begin
				next_state.write_code_a_ps = frsr_pkg::DEFAULT_PS_2M;
			end else if (state.data_rate == frsr_pkg::RATE_1M) begin
				next_state.write_code_a_ps = frsr_pkg::DEFAULT_PS_1M;
			end else begin
				next_state.write_code_a_ps = frsr_pkg::DEFAULT_PS_LOW;
			end
		end else if (state.data_rate == frsr_pkg::RATE_2M) begin
			next_state.write_code_a_ps = frsr_pkg::WRITE_CODE_A_PS_FAST[write_code_a_code];
		end else begin
			next_state.write_code_a_ps = frsr_pkg::WRITE_CODE_A_PS_SLOW[write_code_a_code];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register; of these fields soft reset clears only low_power [RQ3] [RQ5]
	always_ff @(posedge REF_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			state.drive_sel <= frsr_pkg::DRIVE_SEL_RESET;
			state.out_reset_n <= frsr_pkg::OUT_RESET_N_RESET;
			state.boot_drive <= 2'h0;
			state.tape_sel <= 2'h0;
			state.rate_select <= frsr_pkg::RATE_SELECT_RESET; // [RQ3]
			state.rate_select_shadow <= frsr_pkg::RATE_SELECT_RESET;
			state.active_rate <= frsr_pkg::CODE_250; // [RQ5]
			state.low_power <= 1'b0;
			state.pulse_count <= 4'h0;
			state.ctrl_reset <= 1'b1;
			state.start_track <= frsr_pkg::START_TRACK_RESET; // [RQ7]
			state.rdata <= 8'h00;
			state.rvalid <= 1'b0;
			state.data_rate <= frsr_pkg::RATE_250K;
			state.density <= frsr_pkg::DENSITY_RESET;
			state.drive_density_out_hi <= 1'b0;
			state.drive_density_out_lo <= 1'b0;
			state.write_code_a_ps <= frsr_pkg::DEFAULT_PS_LOW;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign IO_RDATA_O = state.rdata;
	assign IO_RVALID_O = state.rvalid;
	assign CTRL_RESET_O = state.ctrl_reset;
	assign LOW_POWER_O = state.low_power;
	assign DRIVE_SEL_O = state.drive_sel;
	assign TAPE_SEL_O = state.tape_sel;
	assign DATA_RATE_O = state.data_rate;
	assign WRITE_CODE_A_O = write_code_a_code;
	assign WRITE_CODE_A_DELAY_PS_O = state.write_code_a_ps;
	assign WRITE_CODE_A_START_TRACK_O = state.start_track;
	assign DENSITY_SELECT_OUT_O = state.density;
	assign DRIVE_DENSITY_OUT_HI_O = state.drive_density_out_hi;
	assign DRIVE_DENSITY_OUT_LO_O = state.drive_density_out_lo;
	assign RATE_SELECT_SHADOW_O = state.rate_select_shadow;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_status_read_live: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RQ14]
		rd_status |=> IO_RVALID_O && (IO_RDATA_O[7:4] == $past(status_read[7:4]))
			&& (IO_RDATA_O[1:0] == {$past(STATUS_I.drive1_seeking),
			$past(STATUS_I.drive0_seeking)}))
		else $error("status read did not return live flags");

	a_status_reserved_zero: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RQ24]
		rd_status |=> IO_RDATA_O[3:2] == 2'b00)
		else $error("reserved status bits not zero");

	a_drive_type_pair: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RQ2]
		IO_READ_I && ENHANCED_MODE2_I && (IO_ADDR_I == frsr_pkg::ADDR_TAPE_DRIVE_TYPE)
		|=> IO_RDATA_O[5:4] == $past(DRIVE_TYPE_CONFIG_I[{state.drive_sel, 1'b0} +: 2])
			&& IO_RDATA_O[7:6] == 2'b00)
		else $error("drive type id wrong pair");

	a_rate_self_clear: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RQ9]
		wr_rate && IO_WDATA_I[7] && state.out_reset_n
		|=> CTRL_RESET_O ##1 (!CTRL_RESET_O || !state.out_reset_n || $past(wr_rate)))
		else $error("rate select reset did not pulse once");

	a_out_reset_hold: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RQ23]
		!state.out_reset_n |-> CTRL_RESET_O)
		else $error("controller left reset while output register bit low");

	a_low_power_exit: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RQ8]
		LOW_POWER_O && (rd_status || data_access) && !wr_rate |=> !LOW_POWER_O)
		else $error("low power not left on access");

	a_low_power_enter: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RQ8]
		wr_rate && IO_WDATA_I[6] |=> LOW_POWER_O)
		else $error("low power not entered");

	a_rate_last_write: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RQ4]
		wr_cfg_ctrl && IO_WDATA_I[1:0] == frsr_pkg::CODE_1M ##1 !wr_rate && !wr_cfg_ctrl
		|=> DATA_RATE_O == frsr_pkg::RATE_1M)
		else $error("config control write did not set rate");

	a_rate_shadow: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RQ21]
		wr_rate |=> RATE_SELECT_SHADOW_O == $past(IO_WDATA_I))
		else $error("shadow not updated");

	a_density_code: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RQ11]
		// density leaves reset high, so the first update after release is skipped
		$past(rst_n) && !wr_rate && !wr_cfg_ctrl |=> DENSITY_SELECT_OUT_O ==
			($past(state.active_rate) == 2'b11 || $past(state.active_rate) == 2'b00))
		else $error("density output mismatch");

	a_write_code_a_zero: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RQ6]
		wr_rate && IO_WDATA_I[4:2] == 3'b111 ##1 !wr_rate |=> WRITE_CODE_A_DELAY_PS_O == 18'h0)
		else $error("write_code_a code 111 not zero");

endmodule : frsr_top

// *** verif/frsr_host_model.sv ***
// host processor model: issues 8-bit I/O accesses on the block's strobe port
// assumes one access at a time, strobes launched on the falling clock edge
`timescale 1ns/1ps
module frsr_host_model (
	// clock
	input wire logic clk_i,
	// read return
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i,
	// strobe port
	output logic [15:0] addr_o,
	output logic write_o,
	output logic read_o,
	output logic [7:0] wdata_o
);
	initial begin
		addr_o = 16'h0000;
		write_o = 1'b0;
		read_o = 1'b0;
		wdata_o = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = (a == frsr_pkg::ADDR_RATE_STATUS) ? (d & 8'hDF) : d;
		write_o = 1'b1;
		@(negedge clk_i);
		write_o = 1'b0;
		// released bus must not look like the last value
		wdata_o = ~wdata_o;
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		read_o = 1'b1;
		@(negedge clk_i);
		// the answer stands only for the cycle after the strobe
		d = rvalid_i ? rdata_i : 8'hxx;
		read_o = 1'b0;
	endtask : rd

	// the data byte is read once the status says the port is ready, or after eight status polls
	task automatic data_rd(output logic [7:0] d);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 8 && s[7] !== 1'b1; i++) rd(frsr_pkg::ADDR_RATE_STATUS, s);
		rd(frsr_pkg::ADDR_DATA, d);
	endtask : data_rd
endmodule : frsr_host_model

// *** verif/frsr_top_tb.sv ***
// testbench for the rate and status register bank
// assumes a 10 MHz clock and the host model for all register traffic
`timescale 1ns/1ps
module frsr_top_tb;
	localparam logic [15:0] OUT_REG = frsr_pkg::ADDR_DIGITAL_OUTPUT;
	localparam logic [15:0] TAPE_REG = frsr_pkg::ADDR_TAPE_DRIVE_TYPE;
	localparam logic [15:0] RS = frsr_pkg::ADDR_RATE_STATUS;
	localparam logic [15:0] CFG_CTRL = frsr_pkg::ADDR_CONFIG_CONTROL;
	// pairs 11,10,01,00: the drive type is never equal to the drive select code
	localparam logic [1:0] DD_EXP [4] = '{2'b01, 2'b10, 2'b11, 2'b10};
	logic clk = 1'b0;
	logic [7:0] dtc = 8'h1B;
	logic reset_n = 1'b0;
	logic enhanced = 1'b0;
	logic [1:0] field = 2'h0;
	logic track_load = 1'b0;
	logic [7:0] track = 8'h00;
	frsr_pkg::frsr_status_type status = '0;
	logic [15:0] addr;
	logic wr_s, rd_s, rvalid, ctrl_rst, low_pwr, dens, ddh, ddl;
	logic [7:0] wdata, rdata, ptrack, shadow, rv;
	logic [1:0] dsel, tsel;
	logic [2:0] wcode;
	logic [17:0] pdly;
	frsr_pkg::frsr_rate_type rate;
	int n_fail = 0;
	int total_checks = 0;

	always #50 clk = ~clk;

	frsr_host_model host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
		.write_o(wr_s), .read_o(rd_s), .wdata_o(wdata));

	frsr_top dut (.REF_CLK_I(clk), .RESET_N_I(reset_n), .IO_ADDR_I(addr), .IO_WRITE_I(wr_s),
		.IO_READ_I(rd_s), .IO_WDATA_I(wdata), .IO_RDATA_O(rdata), .IO_RVALID_O(rvalid),
		.ENHANCED_MODE2_I(enhanced), .DRIVE_TYPE_CONFIG_I(dtc), .DRIVE_RATE_FIELD_I(field),
		.START_TRACK_LOAD_I(track_load), .START_TRACK_I(track), .STATUS_I(status),
		.CTRL_RESET_O(ctrl_rst), .LOW_POWER_O(low_pwr), .DRIVE_SEL_O(dsel), .TAPE_SEL_O(tsel),
		.DATA_RATE_O(rate), .WRITE_CODE_A_O(wcode), .WRITE_CODE_A_DELAY_PS_O(pdly),
		.WRITE_CODE_A_START_TRACK_O(ptrack), .DENSITY_SELECT_OUT_O(dens),
		.DRIVE_DENSITY_OUT_HI_O(ddh), .DRIVE_DENSITY_OUT_LO_O(ddl),
		.RATE_SELECT_SHADOW_O(shadow));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [17:0] e, input logic [17:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	// decoded outputs lag the stored code by up to two cycles
	task automatic settle();
		repeat (4) @(negedge clk);
	endtask : settle

	function automatic frsr_pkg::frsr_rate_type exp_rate(input logic [1:0] f, input logic [1:0] c);
		case (c)
			2'h3: return frsr_pkg::RATE_1M;
			2'h0: return frsr_pkg::RATE_500K;
			2'h2: return frsr_pkg::RATE_250K;
			default: return f == 2'h1 ? frsr_pkg::RATE_500K :
				f == 2'h2 ? frsr_pkg::RATE_2M : frsr_pkg::RATE_300K;
		endcase
	endfunction : exp_rate

	task automatic after_hw_reset();
		chk("ctrl_reset", 1, ctrl_rst);
		chk("low_power", 0, low_pwr);
		chk("shadow", 8'h02, shadow);
		chk("rate", frsr_pkg::RATE_250K, rate);
		chk("drive_sel", 0, dsel);
	endtask : after_hw_reset

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#1_000_000;
		n_fail++;
		results();
	end

	initial begin
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		repeat (3) @(negedge clk);
		after_hw_reset();
		chk("write_code_a", frsr_pkg::DEFAULT_PS_LOW, pdly);
		chk("start_track", 0, ptrack);
		host.wr(OUT_REG, 8'h04);
		settle();
		chk("ctrl_reset", 0, ctrl_rst);
		$display("test reset_values done");
		for (int f = 0; f < 3; f++) begin
			field = 2'(f);
			for (int c = 0; c < 4; c++) begin
				host.wr(RS, 8'h1C | 8'(c));
				settle();
				chk("rate", exp_rate(2'(f), 2'(c)), rate);
				chk("density", (c == 3 || c == 0), dens);
				chk("shadow", 8'h1C | 8'(c), shadow);
				chk("write_code_a", 0, pdly);
			end
		end
		$display("test rate_decode done");
		for (int k = 0; k < 2; k++) begin
			field = k ? 2'h2 : 2'h0;
			for (int q = 0; q < 7; q++) begin
				host.wr(RS, {3'h0, 3'(q), k ? 2'h1 : 2'h2});
				settle();
				chk("write_code", q, wcode);
				chk("write_code_a", q == 0 ? (k ? frsr_pkg::DEFAULT_PS_2M : frsr_pkg::DEFAULT_PS_LOW) :
					k ? frsr_pkg::WRITE_CODE_A_PS_FAST[q] : frsr_pkg::WRITE_CODE_A_PS_SLOW[q], pdly);
			end
		end
		field = 2'h0;
		host.wr(RS, 8'h03);
		settle();
		chk("write_code_a", frsr_pkg::DEFAULT_PS_1M, pdly);
		track = 8'h05;
		track_load = 1'b1;
		@(negedge clk);
		track_load = 1'b0;
		settle();
		chk("start_track", 8'h05, ptrack);
		$display("test write_code_a done");
		host.wr(RS, 8'h1C);
		host.wr(CFG_CTRL, 8'h03);
		settle();
		chk("rate", frsr_pkg::RATE_1M, rate);
		chk("shadow", 8'h1C, shadow);
		host.wr(RS, 8'h1E);
		settle();
		chk("rate", frsr_pkg::RATE_250K, rate);
		$display("test latest_write done");
		host.wr(RS, 8'h1D);
		enhanced = 1'b1;
		host.wr(TAPE_REG, 8'hFE);
		for (int ds = 0; ds < 4; ds++) begin
			host.wr(OUT_REG, 8'h04 | 8'(ds));
			settle();
			host.rd(TAPE_REG, rv);
			chk("tape_reg", {2'b00, 2'(3 - ds), 4'hE}, rv);
			chk("drive_sel", ds, dsel);
			chk("tape_sel", 2, tsel);
			chk("drive_density", DD_EXP[ds], {ddh, ddl});
		end
		enhanced = 1'b0;
		host.rd(TAPE_REG, rv);
		chk("tape_reg", 8'h02, rv);
		$display("test drive_type done");
		for (int s = 0; s < 4; s++) begin
			status = frsr_pkg::frsr_status_type'(6'h3F >> (s * 2));
			host.rd(RS, rv);
			chk("status", {status[5:2], 2'b00, status[1:0]}, rv);
		end
		status = frsr_pkg::frsr_status_type'(6'h2A);
		host.data_rd(rv);
		host.rd(RS, rv);
		chk("status", 8'hA2, rv);
		$display("test status done");
		host.wr(RS, 8'h42);
		settle();
		chk("low_power", 1, low_pwr);
		chk("shadow", 8'h42, shadow);
		host.rd(RS, rv);
		chk("low_power", 0, low_pwr);
		host.wr(RS, 8'h42);
		host.data_rd(rv);
		chk("low_power", 0, low_pwr);
		host.wr(RS, 8'h43);
		host.wr(OUT_REG, 8'h00);
		repeat (3) @(negedge clk);
		chk("ctrl_reset", 1, ctrl_rst);
		chk("low_power", 0, low_pwr);
		host.wr(OUT_REG, 8'h04);
		settle();
		chk("ctrl_reset", 0, ctrl_rst);
		chk("rate", frsr_pkg::RATE_1M, rate);
		chk("shadow", 8'h43, shadow);
		host.wr(RS, 8'h43);
		host.wr(RS, 8'h83);
		// the pulse lasts exactly one clock, the shortest legal controller reset
		chk("soft_reset_pulse", 1, ctrl_rst);
		@(negedge clk);
		chk("soft_reset_clear", 0, ctrl_rst);
		settle();
		chk("ctrl_reset", 0, ctrl_rst);
		chk("low_power", 0, low_pwr);
		chk("rate", frsr_pkg::RATE_1M, rate);
		chk("shadow", 8'h83, shadow);
		$display("test low_power_and_soft_reset done");
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		repeat (3) @(negedge clk);
		after_hw_reset();
		$display("test second_reset done");
		results();
	end
endmodule : frsr_top_tb
